/* File: i2c_slave_consts.svh */
`ifndef I2C_SLAVE_CONSTS_SVH
`define I2C_SLAVE_CONSTS_SVH

// ***********************************
// clock and bus timing
// ***********************************
`define CLK_PERIOD_NS      10
`define DATA_SETUP_NS      250
`define DATA_SETUP_CYCLES  ((`DATA_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ***********************************
// framing
// ***********************************
`define BITS_PER_BYTE      4'h8
`define LAST_DATA_BIT      4'h7

// ***********************************
// address layout (7-bit form, direction bit excluded)
// ***********************************
`define FIRST_ADDR_UPPER   4'h4
`define STRAP_PORT1_MSB    1'h0
`define STRAP_PORT2_MSB    1'h1
`define SECOND_ADDR_PORT1  7'h38
`define SECOND_ADDR_PORT2  7'h3F

// ***********************************
// interrupt event bits
// ***********************************
`define EVT_ADDR_MATCH     0
`define EVT_BYTE_RX        1
`define EVT_TX_REQ         2
`define EVT_STOP           3
`define EVT_COUNT          4

`endif

/* File: i2c_slave_pkg.sv */
package i2c_slave_pkg;

	typedef enum logic [3:0] {
		PH_IDLE,
		PH_ADDR,
		PH_ADDR_ACK,
		PH_WR_BYTE,
		PH_WR_ACK,
		PH_RD_LOAD,
		PH_RD_BYTE,
		PH_RD_ACK,
		PH_IGNORE
	} slave_phase_t;

	typedef struct packed {
		logic       valid;
		logic       port;
		logic [7:0] data;
	} rx_byte_t;

	typedef struct packed {
		slave_phase_t phase;
		logic         scl_s1;
		logic         scl_s2;
		logic         scl_prev;
		logic         sda_s1;
		logic         sda_s2;
		logic         sda_prev;
		logic [7:0]   shreg;
		logic [3:0]   bitcnt;
		logic         port;
		logic         rw;
		logic         ack_seen;
		logic [7:0]   timer;
		logic         sda_oe;
		logic         scl_oe;
		logic         tx_req;
		logic         irq;
		rx_byte_t     rx;
	} slave_state_t;

	typedef struct packed {
		slave_state_t [1:0] slv;
		logic [1:0]         strap_step;
		logic               cfg_done;
		logic               pin_low;
	} top_state_t;

endpackage : i2c_slave_pkg

/* File: dual_i2c_slave.sv */
`timescale 1ns/1ps
`include "i2c_slave_consts.svh"

// Notes on behaviour
// [R1] works at standard and fast mode bit rates
// [R2] master opens every transaction with a start condition
// [R3] master closes a transaction with a stop condition
// [R4] address byte follows start, msb first, direction bit last
// [R5] matching address is acked low through the ninth clock high phase
// [R6] one bit per clock pulse; data change while clock high means start/stop
// [R7] any number of bytes, each eight bits then one ack slot
// [R8] transmitter releases data after eighth bit for the receiver ack
// [R9] addressed for write, every received byte is acked
// [R10] master acks each read byte except the last
// [R11] on master nack the device releases data so master can stop
// [R12] master starts a new transfer only while the bus is idle
// [R13] device may hold clock low after a byte until ready
// [R14] master waits for the clock to really rise before finishing a bit
// [R15] master keeps a stretched clock high a minimum time afterwards
// [R16] each slave answers two addresses, one per type-c port
// [R17] no response until boot configuration of addresses is done
// [R18] first slave address is 0100 plus three strap bits
// [R19] each address bit maskable and replaceable per port by firmware
// [R20] each slave has its own interrupt mask driving its irq line
// [R21] first interface defaults to slave, second slave only, third master only
// [R22] second slave uses fixed addresses, not the strap
// [R23] second slave addresses are 0111000 and 0111111
// [R24] strap codes 000-011 for port one, 100-111 for port two
// [R25] non-matching address leaves data released until next start
// [R26] stop ends any transfer and returns to idle
module dual_i2c_slave (
	input  wire logic                            clk,
	input  wire logic                            reset,
	input  wire logic                            boot_done,
	input  wire logic                            first_master_select,
	input  wire logic [1:0]                      address_strap_input,
	input  wire logic [1:0][1:0][6:0]            addr_mask,
	input  wire logic [1:0][1:0][6:0]            addr_value,
	input  wire logic [1:0][`EVT_COUNT-1:0]      irq_mask,
	input  wire logic [1:0][7:0]                 tx_data,
	input  wire logic [1:0]                      tx_valid,
	output logic [1:0]                           tx_req,
	output i2c_slave_pkg::rx_byte_t [1:0]        rx_byte,
	output logic                                 first_host_irq_line,
	output logic                                 second_host_irq_line,
	input  wire logic                            first_slave_clock_pin_in,
	output logic                                 first_slave_clock_pin_out,
	output logic                                 first_slave_clock_pin_oe,
	input  wire logic                            first_slave_data_pin_in,
	output logic                                 first_slave_data_pin_out,
	output logic                                 first_slave_data_pin_oe,
	input  wire logic                            second_slave_clock_pin_in,
	output logic                                 second_slave_clock_pin_out,
	output logic                                 second_slave_clock_pin_oe,
	input  wire logic                            second_slave_data_pin_in,
	output logic                                 second_slave_data_pin_out,
	output logic                                 second_slave_data_pin_oe
);

	i2c_slave_pkg::top_state_t        st_reg;
	i2c_slave_pkg::top_state_t        st_next;
	logic [1:0]                       scl_pin;
	logic [1:0]                       sda_pin;
	logic [1:0]                       scl_rise;
	logic [1:0]                       scl_fall;
	logic [1:0]                       start_seen;
	logic [1:0]                       stop_seen;
	logic [1:0]                       slave_on;
	logic [2:0]                       strap_code_port_one;
	logic [2:0]                       strap_code_port_two;
	logic [1:0][1:0][6:0]             addr_dflt;
	logic [1:0][1:0][6:0]             addr_eff;
	logic [1:0][`EVT_COUNT-1:0]       evt;

	assign scl_pin[0] = first_slave_clock_pin_in;
	assign scl_pin[1] = second_slave_clock_pin_in;
	assign sda_pin[0] = first_slave_data_pin_in;
	assign sda_pin[1] = second_slave_data_pin_in;

	// ***********************************
	// address selection
	// ***********************************
	// strap step is caught once, when boot configuration completes
	assign strap_code_port_one = {`STRAP_PORT1_MSB, st_reg.strap_step};  // see [R24]
	assign strap_code_port_two = {`STRAP_PORT2_MSB, st_reg.strap_step};  // see [R24]
	assign addr_dflt[0][0] = {`FIRST_ADDR_UPPER, strap_code_port_one};   // see [R18]
	assign addr_dflt[0][1] = {`FIRST_ADDR_UPPER, strap_code_port_two};   // see [R18]
	assign addr_dflt[1][0] = `SECOND_ADDR_PORT1;                         // see [R22] see [R23]
	assign addr_dflt[1][1] = `SECOND_ADDR_PORT2;                         // see [R22] see [R23]

	genvar gi;
	genvar gp;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_slave
			for (gp = 0; gp < 2; gp++) begin : g_port
				// per-bit firmware override, independent per port
				assign addr_eff[gi][gp] = (addr_dflt[gi][gp] & ~addr_mask[gi][gp])
					| (addr_value[gi][gp] & addr_mask[gi][gp]);  // see [R19]
			end
			// edges are taken only from synchronised samples
			assign scl_rise[gi]   = st_reg.slv[gi].scl_s2 & ~st_reg.slv[gi].scl_prev;
			assign scl_fall[gi]   = ~st_reg.slv[gi].scl_s2 & st_reg.slv[gi].scl_prev;
			assign start_seen[gi] = st_reg.slv[gi].scl_s2 & st_reg.slv[gi].scl_prev
				& st_reg.slv[gi].sda_prev & ~st_reg.slv[gi].sda_s2;  // see [R2] see [R6]
			assign stop_seen[gi]  = st_reg.slv[gi].scl_s2 & st_reg.slv[gi].scl_prev
				& ~st_reg.slv[gi].sda_prev & st_reg.slv[gi].sda_s2;  // see [R3] see [R6]
		end
	endgenerate

	// first interface stays silent while its role is master
	assign slave_on[0] = st_reg.cfg_done & ~first_master_select;  // see [R17] see [R21]
	assign slave_on[1] = st_reg.cfg_done;                         // see [R17] see [R21]

	// ***********************************
	// next state
	// ***********************************
	always_comb begin
		st_next = st_reg;
		evt     = '0;
		st_next.pin_low = 1'b0;
		st_next.cfg_done = st_reg.cfg_done | boot_done;  // see [R17]
		if (boot_done && !st_reg.cfg_done) begin
			st_next.strap_step = address_strap_input;  // see [R24]
		end
		for (int i = 0; i < 2; i++) begin
			st_next.slv[i].scl_s1   = scl_pin[i];
			st_next.slv[i].scl_s2   = st_reg.slv[i].scl_s1;
			st_next.slv[i].scl_prev = st_reg.slv[i].scl_s2;
			st_next.slv[i].sda_s1   = sda_pin[i];
			st_next.slv[i].sda_s2   = st_reg.slv[i].sda_s1;
			st_next.slv[i].sda_prev = st_reg.slv[i].sda_s2;
			st_next.slv[i].rx.valid = 1'b0;
			st_next.slv[i].tx_req   = 1'b0;
			if (!slave_on[i]) begin
				st_next.slv[i].phase  = i2c_slave_pkg::PH_IDLE;
				st_next.slv[i].sda_oe = 1'b0;
				st_next.slv[i].scl_oe = 1'b0;
			end else if (stop_seen[i]) begin
				if (st_reg.slv[i].phase != i2c_slave_pkg::PH_IDLE
					&& st_reg.slv[i].phase != i2c_slave_pkg::PH_IGNORE) begin
					evt[i][`EVT_STOP] = 1'b1;
				end
				st_next.slv[i].phase  = i2c_slave_pkg::PH_IDLE;  // see [R26]
				st_next.slv[i].sda_oe = 1'b0;
				st_next.slv[i].scl_oe = 1'b0;
			end else if (start_seen[i]) begin
				// repeated start is accepted from any phase
				st_next.slv[i].phase  = i2c_slave_pkg::PH_ADDR;  // see [R4] see [R25]
				st_next.slv[i].bitcnt = '0;
				st_next.slv[i].sda_oe = 1'b0;
				st_next.slv[i].scl_oe = 1'b0;
			end else begin
				case (st_reg.slv[i].phase)
				i2c_slave_pkg::PH_ADDR,
				i2c_slave_pkg::PH_WR_BYTE: begin
					if (scl_rise[i]) begin
						st_next.slv[i].shreg  = {st_reg.slv[i].shreg[6:0], st_reg.slv[i].sda_s2};
						st_next.slv[i].bitcnt = st_reg.slv[i].bitcnt + 4'h1;  // see [R6]
					end else if (scl_fall[i] && st_reg.slv[i].bitcnt == `BITS_PER_BYTE) begin
						if (st_reg.slv[i].phase == i2c_slave_pkg::PH_WR_BYTE) begin
							st_next.slv[i].rx.valid = 1'b1;
							st_next.slv[i].rx.port  = st_reg.slv[i].port;
							st_next.slv[i].rx.data  = st_reg.slv[i].shreg;
							st_next.slv[i].sda_oe   = 1'b1;  // see [R9] see [R7]
							st_next.slv[i].phase    = i2c_slave_pkg::PH_WR_ACK;
							evt[i][`EVT_BYTE_RX]    = 1'b1;
						end else if (st_reg.slv[i].shreg[7:1] == addr_eff[i][0]
							|| st_reg.slv[i].shreg[7:1] == addr_eff[i][1]) begin
							// first address routes to port one, second to port two
							st_next.slv[i].port   = (st_reg.slv[i].shreg[7:1]
								!= addr_eff[i][0]);  // see [R16]
							st_next.slv[i].rw     = st_reg.slv[i].shreg[0];
							st_next.slv[i].sda_oe = 1'b1;  // see [R5]
							st_next.slv[i].phase  = i2c_slave_pkg::PH_ADDR_ACK;
							evt[i][`EVT_ADDR_MATCH] = 1'b1;
						end else begin
							st_next.slv[i].phase  = i2c_slave_pkg::PH_IGNORE;  // see [R25]
						end
					end
				end
				i2c_slave_pkg::PH_ADDR_ACK: begin
					if (scl_fall[i]) begin
						st_next.slv[i].sda_oe = 1'b0;
						st_next.slv[i].bitcnt = '0;
						if (st_reg.slv[i].rw) begin
							// hold clock low until the core hands over a byte
							st_next.slv[i].phase  = i2c_slave_pkg::PH_RD_LOAD;
							st_next.slv[i].scl_oe = 1'b1;  // see [R13]
							st_next.slv[i].tx_req = 1'b1;
							st_next.slv[i].timer  = '0;
							evt[i][`EVT_TX_REQ]   = 1'b1;
						end else begin
							st_next.slv[i].phase  = i2c_slave_pkg::PH_WR_BYTE;
						end
					end
				end
				i2c_slave_pkg::PH_WR_ACK: begin
					if (scl_fall[i]) begin
						st_next.slv[i].sda_oe = 1'b0;
						st_next.slv[i].bitcnt = '0;
						st_next.slv[i].phase  = i2c_slave_pkg::PH_WR_BYTE;
					end
				end
				i2c_slave_pkg::PH_RD_LOAD: begin
					if (st_reg.slv[i].timer == 8'h00) begin
						if (tx_valid[i]) begin
							st_next.slv[i].shreg  = tx_data[i];
							st_next.slv[i].sda_oe = ~tx_data[i][7];
							st_next.slv[i].timer  = 8'(`DATA_SETUP_CYCLES);
						end
					end else begin
						// data settles for the setup time before the clock is let go
						st_next.slv[i].timer = st_reg.slv[i].timer - 8'h01;  // see [R1]
						if (st_reg.slv[i].timer == 8'h01) begin
							st_next.slv[i].scl_oe = 1'b0;  // see [R13]
							st_next.slv[i].bitcnt = '0;
							st_next.slv[i].phase  = i2c_slave_pkg::PH_RD_BYTE;
						end
					end
				end
				i2c_slave_pkg::PH_RD_BYTE: begin
					if (scl_fall[i]) begin
						st_next.slv[i].bitcnt = st_reg.slv[i].bitcnt + 4'h1;
						if (st_reg.slv[i].bitcnt == `LAST_DATA_BIT) begin
							st_next.slv[i].sda_oe = 1'b0;  // see [R8]
							st_next.slv[i].phase  = i2c_slave_pkg::PH_RD_ACK;
						end else begin
							st_next.slv[i].shreg  = {st_reg.slv[i].shreg[6:0], 1'b0};
							st_next.slv[i].sda_oe = ~st_reg.slv[i].shreg[6];
						end
					end
				end
				i2c_slave_pkg::PH_RD_ACK: begin
					if (scl_rise[i]) begin
						st_next.slv[i].ack_seen = ~st_reg.slv[i].sda_s2;  // see [R10]
					end else if (scl_fall[i]) begin
						if (st_reg.slv[i].ack_seen) begin
							st_next.slv[i].phase  = i2c_slave_pkg::PH_RD_LOAD;
							st_next.slv[i].scl_oe = 1'b1;  // see [R13]
							st_next.slv[i].tx_req = 1'b1;
							st_next.slv[i].timer  = '0;
							evt[i][`EVT_TX_REQ]   = 1'b1;
						end else begin
							// nack: line stays released, wait for stop
							st_next.slv[i].phase  = i2c_slave_pkg::PH_IGNORE;  // see [R11]
						end
					end
				end
				i2c_slave_pkg::PH_IDLE,
				i2c_slave_pkg::PH_IGNORE: begin
					st_next.slv[i].sda_oe = 1'b0;
					st_next.slv[i].scl_oe = 1'b0;
				end
				default: begin
					st_next.slv[i].phase = i2c_slave_pkg::PH_IDLE;
				end
				endcase
			end
			st_next.slv[i].irq = |(evt[i] & irq_mask[i]);  // see [R20]
		end
	end

	// ***********************************
	// state register
	// ***********************************
	always_ff @(posedge clk) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ***********************************
	// outputs, all straight from the state register
	// ***********************************
	assign tx_req[0]                  = st_reg.slv[0].tx_req;
	assign tx_req[1]                  = st_reg.slv[1].tx_req;
	assign rx_byte[0]                 = st_reg.slv[0].rx;
	assign rx_byte[1]                 = st_reg.slv[1].rx;
	assign first_host_irq_line        = st_reg.slv[0].irq;
	assign second_host_irq_line       = st_reg.slv[1].irq;
	assign first_slave_clock_pin_out  = st_reg.pin_low;
	assign first_slave_clock_pin_oe   = st_reg.slv[0].scl_oe;
	assign first_slave_data_pin_out   = st_reg.pin_low;
	assign first_slave_data_pin_oe    = st_reg.slv[0].sda_oe;
	assign second_slave_clock_pin_out = st_reg.pin_low;
	assign second_slave_clock_pin_oe  = st_reg.slv[1].scl_oe;
	assign second_slave_data_pin_out  = st_reg.pin_low;
	assign second_slave_data_pin_oe   = st_reg.slv[1].sda_oe;

endmodule : dual_i2c_slave

/* File: i2c_slave_props.sv */
`timescale 1ns/1ps
`include "i2c_slave_consts.svh"
// ************************************
// slave bus properties
// ************************************
module i2c_slave_props (
	input wire logic                             clk,
	input wire logic                             reset,
	input wire logic                             boot_done,
	input wire logic                             first_master_select,
	input wire logic [1:0][`EVT_COUNT-1:0]       irq_mask,
	input wire logic [1:0][7:0]                  tx_data,
	input wire logic [1:0]                       tx_valid,
	input wire logic [1:0]                       tx_req,
	input wire i2c_slave_pkg::rx_byte_t [1:0]    rx_byte,
	input wire logic                             first_host_irq_line,
	input wire logic                             first_slave_clock_pin_in,
	input wire logic                             first_slave_clock_pin_oe,
	input wire logic                             first_slave_data_pin_oe,
	input wire logic                             second_slave_clock_pin_in,
	input wire logic                             second_slave_data_pin_oe
);
	logic booted_reg;

	always_ff @(posedge clk) begin
		if (reset)
			booted_reg <= 1'b0;
		else if (boot_done)
			booted_reg <= 1'b1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_supply;
		tx_req[0] ##1 tx_valid[0];
	endsequence

	a_boot_idle: assert property (
		!booted_reg |-> !first_slave_data_pin_oe && !second_slave_data_pin_oe)
		else $error("bus answered before boot");
	a_rx_with_ack: assert property (rx_byte[0].valid |-> $rose(first_slave_data_pin_oe))
		else $error("byte taken without ack");
	a_tx_req_pulse: assert property (tx_req[0] |=> !tx_req[0])
		else $error("byte request longer than one cycle");
	a_stretch_on_req: assert property (tx_req[0] |-> first_slave_clock_pin_oe)
		else $error("clock not held while byte requested");
	a_role_idle: assert property (
		first_master_select[*3] |-> !first_slave_data_pin_oe && !first_slave_clock_pin_oe)
		else $error("slave active in master role");
	a_first_steady: assert property (
		first_slave_clock_pin_in && $past(first_slave_clock_pin_in)
		|-> $stable(first_slave_data_pin_oe))
		else $error("first data moved while clock high");
	a_second_steady: assert property (
		second_slave_clock_pin_in && $past(second_slave_clock_pin_in)
		|-> $stable(second_slave_data_pin_oe))
		else $error("second data moved while clock high");
	a_irq_masked: assert property (first_host_irq_line |-> $past(irq_mask[0]) != '0)
		else $error("interrupt with all events masked");
	a_tx_msb_first: assert property (
		s_supply |=> first_slave_data_pin_oe == !$past(tx_data[0][7]))
		else $error("first read bit is not the msb");
	a_stretch_release: assert property (
		s_supply |=> first_slave_clock_pin_oe[*8] ##[10:30] !first_slave_clock_pin_oe)
		else $error("stretched clock released too early or never");
endmodule : i2c_slave_props

/* File: i2c_host_model.sv */
`timescale 1ns/1ps
// ************************************
// external bus master, one model for both wire pairs, picked by sel
// ************************************
module i2c_host_model #(
	parameter int Q = 20
) (
	input  wire logic       clk,
	input  wire logic [1:0] scl_in,
	input  wire logic [1:0] sda_in,
	output logic [1:0]      scl_oe,
	output logic [1:0]      sda_oe
);
	int sel = 0;
	// quarter bit time, changed between transfers to run another bit rate
	int q = Q;

	initial begin
		scl_oe = '0;
		sda_oe = '0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask : hold

	// wait for the real rise, then keep clock high a while
	task automatic rise();
		int t;
		t = 0;
		scl_oe[sel] <= 1'b0;
		hold(1);
		while (scl_in[sel] !== 1'b1 && t < 5000) begin
			t++;
			@(posedge clk);
		end
		hold(q);
	endtask : rise

	// data moves only while the clock is low
	task automatic bit_io(input logic v, output logic r);
		sda_oe[sel] <= !v;
		hold(q);
		rise();
		r = sda_in[sel];
		hold(q);
		scl_oe[sel] <= 1'b1;
		hold(q);
	endtask : bit_io

	task automatic start();
		sda_oe[sel] <= 1'b0;
		hold(q);
		rise();
		sda_oe[sel] <= 1'b1;
		hold(q);
		scl_oe[sel] <= 1'b1;
		hold(q);
	endtask : start

	task automatic stop();
		sda_oe[sel] <= 1'b1;
		hold(q);
		rise();
		sda_oe[sel] <= 1'b0;
		hold(q);
	endtask : stop

	task automatic put(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, ack);
	endtask : put

	task automatic get(input logic ack_it, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
		bit_io(!ack_it, r);
	endtask : get
endmodule : i2c_host_model

/* File: tb.sv */
`timescale 1ns/1ps
`include "i2c_slave_consts.svh"
module tb;
	logic                         clk, reset, boot_done, first_master_select;
	logic [1:0]                   address_strap_input, tx_valid, tx_req, step;
	logic [1:0][1:0][6:0]         addr_mask, addr_value;
	logic [1:0][`EVT_COUNT-1:0]   irq_mask;
	logic [1:0][7:0]              tx_data;
	i2c_slave_pkg::rx_byte_t [1:0] rx_byte;
	logic                         first_host_irq_line, second_host_irq_line;
	logic [1:0]                   scl_w, sda_w, m_scl_oe, m_sda_oe, d_scl_oe, d_sda_oe;
	logic [1:0]                   d_scl_out, d_sda_out;
	logic [31:0]                  seed = 32'h62;
	logic [9:0]                   rxq[$];
	logic [7:0]                   txq[$];
	int                           fail_count = 0, checks = 0, irq_count = 0, irq2_count = 0;

	// open-drain wires with pull-ups; the device drives its out level while enabled
	assign scl_w = ~m_scl_oe & (~d_scl_oe | d_scl_out);
	assign sda_w = ~m_sda_oe & (~d_sda_oe | d_sda_out);

	dual_i2c_slave u_dual_i2c_slave (.clk, .reset, .boot_done, .first_master_select,
		.address_strap_input, .addr_mask, .addr_value, .irq_mask, .tx_data, .tx_valid,
		.tx_req, .rx_byte, .first_host_irq_line, .second_host_irq_line,
		.first_slave_clock_pin_in(scl_w[0]), .first_slave_clock_pin_out(d_scl_out[0]),
		.first_slave_clock_pin_oe(d_scl_oe[0]), .first_slave_data_pin_in(sda_w[0]),
		.first_slave_data_pin_out(d_sda_out[0]), .first_slave_data_pin_oe(d_sda_oe[0]),
		.second_slave_clock_pin_in(scl_w[1]), .second_slave_clock_pin_out(d_scl_out[1]),
		.second_slave_clock_pin_oe(d_scl_oe[1]), .second_slave_data_pin_in(sda_w[1]),
		.second_slave_data_pin_out(d_sda_out[1]), .second_slave_data_pin_oe(d_sda_oe[1]));
	i2c_host_model mst (.clk, .scl_in(scl_w), .sda_in(sda_w), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic logic [6:0] home(input int i, input int p);
		if (i == 1) return p ? 7'h3F : 7'h38;
		return {4'h4, p[0], step};
	endfunction : home

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task automatic wr(input int i, input logic [6:0] a, input int p, input int n, input logic ok);
		logic ack;
		logic [7:0] d;
		logic [9:0] q[$];
		mst.sel = i;
		mst.start();
		mst.put({a, 1'b0}, ack);
		check("address ack", ack, !ok);
		for (int k = 0; k < n; k++) begin
			d = 8'(xs());
			mst.put(d, ack);
			check("write ack", ack, !ok);
			if (ok) q.push_back({i[0], p[0], d});
		end
		mst.stop();
		mst.hold(10);
		check("byte count", rxq.size(), q.size());
		while (q.size() > 0 && rxq.size() > 0)
			check("byte", rxq.pop_front(), q.pop_front());
		rxq.delete();
	endtask : wr

	task automatic rd(input int i, input logic [6:0] a, input int n);
		logic ack;
		logic [7:0] d;
		mst.sel = i;
		mst.start();
		mst.put({a, 1'b1}, ack);
		check("read address ack", ack, 0);
		for (int k = 0; k < n; k++) begin
			mst.get(k < n - 1, d);
			check("read byte", d, txq.pop_front());
		end
		mst.stop();
		mst.hold(10);
		check("bytes left", txq.size(), 0);
	endtask : rd

	// feed one random byte per request, taken the cycle after it
	always @(posedge clk) begin : tx_feed
		logic [1:0] v;
		logic [1:0][7:0] td;
		logic [7:0] b;
		v = '0;
		td = '0;
		for (int k = 0; k < 2; k++) if (tx_req[k] === 1'b1) begin
			b = 8'(xs());
			td[k] = b;
			v[k] = 1'b1;
			txq.push_back(b);
		end
		tx_data <= td;
		tx_valid <= v;
	end

	always @(posedge clk) begin
		for (int k = 0; k < 2; k++)
			if (rx_byte[k].valid === 1'b1)
				rxq.push_back({k[0], rx_byte[k].port, rx_byte[k].data});
		if (first_host_irq_line === 1'b1) irq_count <= irq_count + 1;
		if (second_host_irq_line === 1'b1) irq2_count <= irq2_count + 1;
	end

	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (100000) @(posedge clk);
		fail_count++;
		$display("[FAIL] watchdog expected finish seen timeout");
		stop_test();
	end

	initial begin
		reset = 1;
		boot_done = 0;
		first_master_select = 0;
		address_strap_input = '0;
		addr_mask = '0;
		addr_value = '0;
		irq_mask = '0;
		step = '0;
		repeat (5) @(posedge clk);
		reset <= 0;
		repeat (4) @(posedge clk);
		wr(0, 7'h20, 0, 1, 0);
		wr(1, 7'h38, 0, 1, 0);
		$display("test boot gate done");
		step = 2'(xs());
		address_strap_input <= step;
		boot_done <= 1;
		@(posedge clk);
		for (int i = 0; i < 2; i++)
			for (int p = 0; p < 2; p++)
				wr(i, home(i, p), p, 1 + int'(xs() % 3), 1);
		$display("test address map done");
		wr(0, 7'h50, 0, 1, 0);
		wr(1, 7'h21, 0, 1, 0);
		$display("test foreign address done");
		addr_mask[1][0] <= 7'h01;
		addr_value[1][0] <= 7'h01;
		@(posedge clk);
		wr(1, 7'h39, 0, 1, 1);
		wr(1, 7'h38, 0, 0, 0);
		addr_mask <= '0;
		$display("test address override done");
		rd(0, home(0, 1), 3);
		rd(1, home(1, 0), 1);
		$display("test read done");
		// both irq counters stay at zero until the masks open here
		irq_mask <= {4'h2, 4'hF};
		@(posedge clk);
		wr(0, home(0, 0), 0, 2, 1);
		check("irq pulses", irq_count, 4);
		wr(1, home(1, 1), 1, 2, 1);
		check("second irq pulses", irq2_count, 2);
		irq_mask <= '0;
		@(posedge clk);
		wr(0, home(0, 1), 1, 1, 1);
		check("masked irq pulses", irq_count, 4);
		$display("test interrupt done");
		first_master_select <= 1;
		@(posedge clk);
		wr(0, home(0, 0), 0, 1, 0);
		first_master_select <= 0;
		@(posedge clk);
		wr(0, home(0, 0), 0, 1, 1);
		$display("test role done");
		// standard mode, then fast mode bit timing
		mst.q = 235;
		wr(1, home(1, 1), 1, 1, 1);
		mst.q = 65;
		rd(0, home(0, 0), 2);
		$display("test bit rate done");
		stop_test();
	end
endmodule : tb

bind dual_i2c_slave i2c_slave_props u_i2c_slave_props (.clk, .reset, .boot_done,
	.first_master_select, .irq_mask, .tx_data, .tx_valid, .tx_req, .rx_byte,
	.first_host_irq_line, .first_slave_clock_pin_in, .first_slave_clock_pin_oe,
	.first_slave_data_pin_oe, .second_slave_clock_pin_in, .second_slave_data_pin_oe);
